/* File: verilog/dalc_top.sv */
// Access-layer control and status registers of the single-wire debug port
// Summary of operation
// - Negative-acknowledge disable bit 4 suppresses the nack on reset during indirect load/store.
// - Contention detect disable bit 3 stops contention detection on the line.
// - Port disable bit 2 turns off the interface, drops clock request, resets keys.
// - Key status bit 5 shows the user-row write key is active.
// - Key status bits 4 and 3 show programming and erase keys, clear when done.
// - Writing 0x59 to the reset request register holds the system in reset.
// - Writing any other value releases the held system reset.
// - Reset request reads bit 0 as the held reset, other bits zero.
// - A system reset from the reset request register never resets the port.
// - Clock select: 1=16 MHz, 2=8 MHz, 3=4 MHz, 0 reserved; 4 MHz after reset/enable.
// - Writing user-row done bit 1 starts programming the user row into flash.
// - User-row done bit is writable only with the user-row key decoded.
// - System clock request bit 0 keeps the system clock running; zero drops it.
// - Clock request sets when the port is enabled, clears when disabled.
// - Status bit 5 sets while the system is in reset and clears when read.
// - Status bit 4 shows the system is in idle or deeper sleep.
// - Status bit 3 shows memory programming may start; programmer then resets system.
// - Status bit 2 shows user-row programming may start; programmer then sets done bit.
// - Status bit 0 shows the device is locked until full erase clears it.
// - Checksum status is one-hot: 0 off, 1 busy, 2 good, 4 failed.
// - Registers are reached only through the port's own register access, not the processor.
module dalc_top (
	// Clock and reset
	input  wire logic                clk_sys,
	input  wire logic                rst_b,
	// Register access from the port's instruction decoder
	input  wire dalc_pkg::dalc_acc_s acc,
	output logic [7:0]               rdata,
	// Port enable request from the physical layer
	input  wire logic                port_enable,
	input  wire logic                load_store_busy,
	// System domain status, asynchronous to this block
	input  wire dalc_pkg::dalc_sys_s sys_in,
	// Controls to physical layer and system
	output logic                     phy_enabled,
	output logic                     contention_detect_on,
	output logic                     send_neg_ack,
	output logic                     keys_clear,
	output logic [1:0]               port_clock_select_field,
	output logic                     system_clock_request,
	output logic                     system_reset_hold,
	output logic                     user_row_done
);

	// ------------------------------------------------------------
	// Synchronisers for system-domain status
	// ------------------------------------------------------------
	dalc_pkg::dalc_sys_s sys_meta;
	dalc_pkg::dalc_sys_s sys_s;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sys_meta <= '0;
			sys_s    <= '0;
		end else begin
			sys_meta <= sys_in;
			sys_s    <= sys_meta;
		end
	end

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction : hit

	wire logic wr_link   = acc.wr && hit(acc.addr, dalc_pkg::OFF_LINK_CTRL_B);
	wire logic wr_reset_request_value = acc.wr && hit(acc.addr, dalc_pkg::OFF_RESET_REQ);
	wire logic wr_clksel = acc.wr && hit(acc.addr, dalc_pkg::OFF_CLOCK_SELECT);
	wire logic wr_sysctl = acc.wr && hit(acc.addr, dalc_pkg::OFF_SYS_CONTROL);
	wire logic rd_status = acc.rd && hit(acc.addr, dalc_pkg::OFF_SYS_STATUS);

	// ------------------------------------------------------------
	// Control state
	// ------------------------------------------------------------
	logic [2:0] link_ctrl;
	logic       rst_hold;
	logic [1:0] clk_sel;
	logic       clk_req;
	logic       in_reset_flag;
	logic       enabled_q;
	logic       port_off;

	// Port disable is a one-shot: it resets the port and clears itself
	wire logic disable_now = wr_link && acc.wdata[dalc_pkg::BIT_PORT_DISABLE];
	// A disabled port stays off until the enable input falls and rises again
	wire logic port_live   = port_enable && !port_off && !disable_now;
	wire logic enable_rise = port_live && !enabled_q;
	// Reserved clock code is refused so the port never runs on an undefined clock
	wire logic clksel_ok = acc.wdata[1:0] != dalc_pkg::CLKSEL_RESERVED;
	wire logic urow_key_ok = sys_s.key_urow;
	wire logic next_in_reset_flag = (sys_s.sys_in_reset || rst_hold) ? 1'b1 :
	                                rd_status ? 1'b0 : in_reset_flag;

	// Only rst_b resets this block; the held system reset never feeds back here
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			enabled_q <= 1'b0;
		end else begin
			enabled_q <= port_live;
		end
	end

	// Set wins over a dropped enable in the same cycle; the enable must fall to re-arm
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			port_off <= 1'b0;
		end else if (disable_now) begin
			port_off <= 1'b1;
		end else if (!port_enable) begin
			port_off <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			link_ctrl <= dalc_pkg::LINK_CTRL_RESET;
		end else if (disable_now) begin
			link_ctrl <= dalc_pkg::LINK_CTRL_RESET;
		end else if (wr_link) begin
			link_ctrl <= acc.wdata[4:2];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_hold <= 1'b0;
		end else if (wr_reset_request_value) begin
			rst_hold <= (acc.wdata == dalc_pkg::RESET_SIGNATURE);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			clk_sel <= dalc_pkg::CLKSEL_4MHZ;
		end else if (disable_now || enable_rise) begin
			clk_sel <= dalc_pkg::CLKSEL_4MHZ;
		end else if (wr_clksel && clksel_ok) begin
			clk_sel <= acc.wdata[1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			clk_req <= 1'b0;
		end else if (!port_live) begin
			clk_req <= 1'b0;
		end else if (enable_rise) begin
			clk_req <= dalc_pkg::CLK_REQ_RESET;
		end else if (wr_sysctl) begin
			clk_req <= acc.wdata[dalc_pkg::BIT_CLK_REQ];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			in_reset_flag <= 1'b0;
		end else begin
			in_reset_flag <= next_in_reset_flag;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	logic [7:0] next_rdata;
	logic [7:0] key_rd;
	logic [7:0] st_rd;

	always_comb begin
		key_rd = 8'h00;
		key_rd[dalc_pkg::BIT_KEY_UROW]  = sys_s.key_urow;
		key_rd[dalc_pkg::BIT_KEY_PROG]  = sys_s.key_prog && !sys_s.prog_done;
		key_rd[dalc_pkg::BIT_KEY_ERASE] = sys_s.key_erase && !sys_s.erase_done;
		st_rd = 8'h00;
		st_rd[dalc_pkg::BIT_ST_RESET]  = in_reset_flag || sys_s.sys_in_reset || rst_hold;
		st_rd[dalc_pkg::BIT_ST_SLEEP]  = sys_s.sys_sleeping;
		st_rd[dalc_pkg::BIT_ST_PROG]   = sys_s.prog_ready;
		st_rd[dalc_pkg::BIT_ST_UROW]   = sys_s.urow_ready;
		st_rd[dalc_pkg::BIT_ST_LOCKED] = sys_s.locked;
		unique case (acc.addr)
			dalc_pkg::OFF_LINK_CTRL_B:  next_rdata = {3'h0, link_ctrl, 2'h0};
			dalc_pkg::OFF_KEY_STATUS:   next_rdata = key_rd;
			dalc_pkg::OFF_RESET_REQ:    next_rdata = {7'h00, rst_hold};
			dalc_pkg::OFF_CLOCK_SELECT: next_rdata = {6'h00, clk_sel};
			dalc_pkg::OFF_SYS_CONTROL:  next_rdata = {7'h00, clk_req};
			dalc_pkg::OFF_SYS_STATUS:   next_rdata = st_rd;
			dalc_pkg::OFF_CRC_STATUS:   next_rdata = {5'h00, sys_s.crc_status};
			default:                    next_rdata = 8'h00;
		endcase
	end

	// The registers have no processor-side port at all
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdata                   <= 8'h00;
			phy_enabled             <= 1'b0;
			contention_detect_on    <= 1'b1;
			send_neg_ack            <= 1'b0;
			keys_clear              <= 1'b1;
			port_clock_select_field <= dalc_pkg::CLKSEL_4MHZ;
			system_clock_request    <= 1'b0;
			system_reset_hold       <= 1'b0;
			user_row_done           <= 1'b0;
		end else begin
			rdata                   <= acc.rd ? next_rdata : 8'h00;
			phy_enabled             <= port_live;
			contention_detect_on    <= !link_ctrl[dalc_pkg::BIT_CONTENTION - 2];
			send_neg_ack            <= load_store_busy && sys_s.sys_in_reset
			                           && !link_ctrl[dalc_pkg::BIT_NEG_ACK_DIS - 2];
			keys_clear              <= !port_live;
			port_clock_select_field <= clk_sel;
			system_clock_request    <= clk_req;
			system_reset_hold       <= rst_hold;
			user_row_done           <= wr_sysctl && urow_key_ok
			                           && acc.wdata[dalc_pkg::BIT_UROW_DONE];
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_reset_sig_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_reset_request_value && acc.wdata == dalc_pkg::RESET_SIGNATURE |=> ##1 system_reset_hold)
		else $error("reset signature did not hold system reset");

	a_reset_release: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_reset_request_value && acc.wdata != dalc_pkg::RESET_SIGNATURE |=> ##1 !system_reset_hold)
		else $error("other value did not release system reset");

	a_clksel_default: assert property (@(posedge clk_sys) disable iff (!rst_b)
		enable_rise |=> ##1 port_clock_select_field == dalc_pkg::CLKSEL_4MHZ)
		else $error("clock select not 4 MHz after enable");

	a_disable_drops: assert property (@(posedge clk_sys) disable iff (!rst_b)
		disable_now |=> ##1 (!system_clock_request && !phy_enabled && keys_clear))
		else $error("port disable did not drop request and reset port");

	a_urow_locked: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_sysctl && !urow_key_ok |=> !user_row_done)
		else $error("user-row done accepted without key");

	a_urow_start: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_sysctl && urow_key_ok && acc.wdata[1] |=> user_row_done)
		else $error("user-row done write did not start programming");

	a_reset_request_value_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
		acc.rd && acc.addr == dalc_pkg::OFF_RESET_REQ |=> rdata == {7'h00, $past(rst_hold)})
		else $error("reset request read value wrong");

	a_nack_masked: assert property (@(posedge clk_sys) disable iff (!rst_b)
		link_ctrl[2] |=> !send_neg_ack)
		else $error("nack sent while disabled");

	a_status_reset: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rst_hold |=> in_reset_flag)
		else $error("reset status not set during held reset");

	a_system_clock_request_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!port_enable |=> ##1 !system_clock_request)
		else $error("clock request kept while port disabled");

	a_system_clock_request_enable: assert property (@(posedge clk_sys) disable iff (!rst_b)
		enable_rise |=> ##1 system_clock_request)
		else $error("clock request not set on enable");

	a_system_clock_request_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_sysctl && !enable_rise && !acc.wdata[dalc_pkg::BIT_CLK_REQ]
		|=> ##1 !system_clock_request)
		else $error("writing zero did not drop clock request");

	a_system_clock_request_one: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_sysctl && port_live && acc.wdata[dalc_pkg::BIT_CLK_REQ]
		|=> ##1 system_clock_request)
		else $error("writing one did not raise clock request");

	a_contention_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_link && !disable_now && acc.wdata[dalc_pkg::BIT_CONTENTION]
		|=> ##1 !contention_detect_on)
		else $error("contention detection still on after disable write");

	a_port_off_phy: assert property (@(posedge clk_sys) disable iff (!rst_b)
		port_off |=> !phy_enabled)
		else $error("interface enabled while port is off");

	a_clksel_reserved: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_clksel && !clksel_ok && !enable_rise |=> $stable(clk_sel))
		else $error("reserved clock code changed the selection");

	a_clksel_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
		wr_clksel && clksel_ok && !enable_rise |=> clk_sel == $past(acc.wdata[1:0]))
		else $error("clock select write not taken");

	a_status_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
		rd_status && !sys_s.sys_in_reset && !rst_hold |=> !in_reset_flag)
		else $error("reset status not cleared by read");

	a_status_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
		sys_s.sys_in_reset |=> in_reset_flag)
		else $error("reset status not set during system reset");

	a_sleep_bit: assert property (@(posedge clk_sys) disable iff (!rst_b)
		acc.rd && acc.addr == dalc_pkg::OFF_SYS_STATUS
		|=> rdata[dalc_pkg::BIT_ST_SLEEP] == $past(sys_s.sys_sleeping))
		else $error("sleep status read wrong");

	a_locked_bit: assert property (@(posedge clk_sys) disable iff (!rst_b)
		acc.rd && acc.addr == dalc_pkg::OFF_SYS_STATUS
		|=> rdata[dalc_pkg::BIT_ST_LOCKED] == $past(sys_s.locked))
		else $error("lock status read wrong");

	a_crc_upper: assert property (@(posedge clk_sys) disable iff (!rst_b)
		acc.rd && acc.addr == dalc_pkg::OFF_CRC_STATUS |=> rdata[7:3] == 5'h00)
		else $error("checksum status upper bits not zero");

endmodule : dalc_top

/* File: verilog/dalc_pkg.sv */
// Package for the debug access layer control block: offsets, fields, resets, carriers
package dalc_pkg;

	// Register offsets on the access-layer register port
	localparam logic [3:0] OFF_LINK_CTRL_B  = 4'h3;
	localparam logic [3:0] OFF_KEY_STATUS   = 4'h7;
	localparam logic [3:0] OFF_RESET_REQ    = 4'h8;
	localparam logic [3:0] OFF_CLOCK_SELECT = 4'h9;
	localparam logic [3:0] OFF_SYS_CONTROL  = 4'ha;
	localparam logic [3:0] OFF_SYS_STATUS   = 4'hb;
	localparam logic [3:0] OFF_CRC_STATUS   = 4'hc;

	// Field positions
	localparam int BIT_NEG_ACK_DIS   = 4;
	localparam int BIT_CONTENTION    = 3;
	localparam int BIT_PORT_DISABLE  = 2;
	localparam int BIT_KEY_UROW      = 5;
	localparam int BIT_KEY_PROG      = 4;
	localparam int BIT_KEY_ERASE     = 3;
	localparam int BIT_UROW_DONE     = 1;
	localparam int BIT_CLK_REQ       = 0;
	localparam int BIT_ST_RESET      = 5;
	localparam int BIT_ST_SLEEP      = 4;
	localparam int BIT_ST_PROG       = 3;
	localparam int BIT_ST_UROW       = 2;
	localparam int BIT_ST_LOCKED     = 0;

	// Values
	localparam logic [7:0] RESET_SIGNATURE  = 8'h59;
	localparam logic [1:0] CLKSEL_RESERVED  = 2'h0;
	localparam logic [1:0] CLKSEL_16MHZ     = 2'h1;
	localparam logic [1:0] CLKSEL_8MHZ      = 2'h2;
	localparam logic [1:0] CLKSEL_4MHZ      = 2'h3;
	localparam logic [2:0] CRC_OFF          = 3'h0;
	localparam logic [2:0] CRC_BUSY         = 3'h1;
	localparam logic [2:0] CRC_GOOD         = 3'h2;
	localparam logic [2:0] CRC_FAIL         = 3'h4;
	localparam logic [2:0] LINK_CTRL_RESET  = 3'h0;
	localparam logic       CLK_REQ_RESET    = 1'b1;

	// Register access strobe from the port's instruction decoder
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} dalc_acc_s;

	// Status coming from the system domain
	typedef struct packed {
		logic       sys_in_reset;
		logic       sys_sleeping;
		logic       prog_ready;
		logic       urow_ready;
		logic       locked;
		logic       key_prog;
		logic       key_erase;
		logic       key_urow;
		logic       prog_done;
		logic       erase_done;
		logic [2:0] crc_status;
	} dalc_sys_s;

endpackage : dalc_pkg

/* File: testbench/dalc_prog_model.sv */
// Programmer-side model: single-byte register accesses on the port
module dalc_prog_model (
	// Clock
	input  wire logic          clk_sys,
	// Register access
	output dalc_pkg::dalc_acc_s acc,
	input  wire logic [7:0]    rdata
);
	timeunit 1ns;
	timeprecision 1ns;

	initial acc = '0;

	// Drives the write strobe for one cycle, from one falling edge to the next
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		acc <= {1'b1, 1'b0, a, d};
		@(negedge clk_sys);
		acc <= '0;
	endtask : wr

	// Data stands only in the cycle after the read edge, so it is taken there
	task rd(input logic [3:0] a, output logic [7:0] d);
		@(negedge clk_sys);
		acc <= {1'b0, 1'b1, a, 8'h00};
		@(negedge clk_sys);
		d = rdata;
		acc <= '0;
	endtask : rd
endmodule : dalc_prog_model

/* File: testbench/test_debug_access_layer_control.sv */
// Self-checking bench for the access-layer control block
module test_debug_access_layer_control;
	timeunit 1ns;
	timeprecision 1ns;

	logic                clk_sys, rst_b, port_enable, load_store_busy;
	dalc_pkg::dalc_sys_s sys_in;
	dalc_pkg::dalc_acc_s acc;
	logic [7:0]          rdata, rv;
	logic                phy_enabled, contention_detect_on, send_neg_ack, keys_clear;
	logic [1:0]          port_clock_select_field;
	logic                system_clock_request, system_reset_hold, user_row_done;
	int                  err_count, num_checks, n;

	dalc_top u_dalc_top (.clk_sys, .rst_b, .acc, .rdata, .port_enable, .load_store_busy,
		.sys_in, .phy_enabled, .contention_detect_on, .send_neg_ack, .keys_clear,
		.port_clock_select_field, .system_clock_request, .system_reset_hold, .user_row_done);
	dalc_prog_model u_dalc_prog_model (.clk_sys, .acc, .rdata);

	//--------------------------------------------------
	// Helpers
	//--------------------------------------------------
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	task cyc(input int k);
		repeat (k) @(negedge clk_sys);
	endtask : cyc

	task rdchk(input logic [3:0] a, input logic [7:0] e);
		u_dalc_prog_model.rd(a, rv);
		chk(rv, e);
	endtask : rdchk

	task wrw(input logic [3:0] a, input logic [7:0] d);
		u_dalc_prog_model.wr(a, d);
		cyc(2);
	endtask : wrw

	task print_verdict;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	//--------------------------------------------------
	// Scenarios
	//--------------------------------------------------
	task t_reset;
		chk(contention_detect_on, 8'h01);
		chk(port_clock_select_field, 8'h03);
		rdchk(dalc_pkg::OFF_CLOCK_SELECT, 8'h03);
		rdchk(dalc_pkg::OFF_RESET_REQ, 8'h00);
		rdchk(dalc_pkg::OFF_SYS_STATUS, 8'h01);
		rdchk(4'h5, 8'h00);
	endtask : t_reset

	task t_system_clock_request;
		port_enable = 1'b1;
		cyc(3);
		chk(system_clock_request, 8'h01);
		rdchk(dalc_pkg::OFF_SYS_CONTROL, 8'h01);
		wrw(dalc_pkg::OFF_SYS_CONTROL, 8'h00);
		chk(system_clock_request, 8'h00);
		wrw(dalc_pkg::OFF_SYS_CONTROL, 8'h01);
		chk(system_clock_request, 8'h01);
	endtask : t_system_clock_request

	task t_reset_request_value;
		wrw(dalc_pkg::OFF_RESET_REQ, dalc_pkg::RESET_SIGNATURE);
		chk(system_reset_hold, 8'h01);
		rdchk(dalc_pkg::OFF_RESET_REQ, 8'h01);
		chk(system_clock_request, 8'h01);
		wrw(dalc_pkg::OFF_RESET_REQ, 8'h58);
		chk(system_reset_hold, 8'h00);
		rdchk(dalc_pkg::OFF_RESET_REQ, 8'h00);
	endtask : t_reset_request_value

	task t_clksel;
		logic [1:0] c [4];
		logic [1:0] e;
		c = '{2'h1, 2'h2, 2'h0, 2'h3};
		e = 2'h3;
		foreach (c[i]) begin
			wrw(dalc_pkg::OFF_CLOCK_SELECT, {6'h0, c[i]});
			if (c[i] != dalc_pkg::CLKSEL_RESERVED) e = c[i];
			chk(port_clock_select_field, e);
		end
	endtask : t_clksel

	task t_link;
		load_store_busy = 1'b1;
		sys_in.sys_in_reset = 1'b1;
		wrw(dalc_pkg::OFF_LINK_CTRL_B, 8'h18);
		cyc(1);
		chk(contention_detect_on, 8'h00);
		chk(send_neg_ack, 8'h00);
		wrw(dalc_pkg::OFF_LINK_CTRL_B, 8'h00);
		chk(send_neg_ack, 8'h01);
		chk(contention_detect_on, 8'h01);
		sys_in.sys_in_reset = 1'b0;
		load_store_busy = 1'b0;
		cyc(3);
		rdchk(dalc_pkg::OFF_SYS_STATUS, 8'h21);
		rdchk(dalc_pkg::OFF_SYS_STATUS, 8'h01);
	endtask : t_link

	// Pulse count of the user-row done strobe after one write; the pulse stands
	// in the cycle in which the write task returns, so counting starts there
	task urow_try(input int exp);
		u_dalc_prog_model.wr(dalc_pkg::OFF_SYS_CONTROL, 8'h03);
		n = 0;
		if (user_row_done === 1'b1) n++;
		repeat (4) begin
			@(negedge clk_sys);
			if (user_row_done === 1'b1) n++;
		end
		chk(n[7:0], exp[7:0]);
	endtask : urow_try

	task t_urow;
		urow_try(0);
		sys_in.key_urow = 1'b1;
		cyc(3);
		rdchk(dalc_pkg::OFF_KEY_STATUS, 8'h20);
		// With the user-row key decoded, the done write gives one pulse
		urow_try(1);
	endtask : t_urow

	task t_status;
		logic [2:0] v [4];
		v = '{3'h0, 3'h1, 3'h2, 3'h4};
		sys_in.key_urow = 1'b0;
		sys_in.sys_sleeping = 1'b1;
		sys_in.prog_ready = 1'b1;
		sys_in.urow_ready = 1'b1;
		sys_in.locked = 1'b0;
		sys_in.key_prog = 1'b1;
		sys_in.key_erase = 1'b1;
		cyc(3);
		rdchk(dalc_pkg::OFF_SYS_STATUS, 8'h1c);
		rdchk(dalc_pkg::OFF_KEY_STATUS, 8'h18);
		sys_in.prog_done = 1'b1;
		sys_in.erase_done = 1'b1;
		cyc(3);
		rdchk(dalc_pkg::OFF_KEY_STATUS, 8'h00);
		foreach (v[i]) begin
			sys_in.crc_status = v[i];
			cyc(3);
			rdchk(dalc_pkg::OFF_CRC_STATUS, {5'h0, v[i]});
		end
	endtask : t_status

	task t_disable;
		wrw(dalc_pkg::OFF_CLOCK_SELECT, 8'h01);
		wrw(dalc_pkg::OFF_LINK_CTRL_B, 8'h04);
		chk(phy_enabled, 8'h00);
		chk(system_clock_request, 8'h00);
		chk(keys_clear, 8'h01);
		chk(port_clock_select_field, 8'h03);
		rdchk(dalc_pkg::OFF_LINK_CTRL_B, 8'h00);
		rdchk(dalc_pkg::OFF_SYS_CONTROL, 8'h00);
		chk(phy_enabled, 8'h00);
		// Re-enable: the port must come back on the default clock with its request set
		port_enable = 1'b0;
		wrw(dalc_pkg::OFF_CLOCK_SELECT, 8'h01);
		port_enable = 1'b1;
		cyc(3);
		chk(system_clock_request, 8'h01);
		chk(port_clock_select_field, 8'h03);
		chk(phy_enabled, 8'h01);
		chk(keys_clear, 8'h00);
	endtask : t_disable

	//--------------------------------------------------
	// Clock, watchdog and main sequence
	//--------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// The whole sequence needs well under 1000 cycles
	initial begin
		#(40 * 5000);
		err_count++;
		print_verdict();
	end

	initial begin
		err_count = 0;
		num_checks = 0;
		rst_b = 1'b0;
		port_enable = 1'b0;
		load_store_busy = 1'b0;
		sys_in = '0;
		sys_in.locked = 1'b1;
		cyc(6);
		rst_b = 1'b1;
		cyc(3);
		t_reset();
		t_system_clock_request();
		t_reset_request_value();
		t_clksel();
		t_link();
		t_urow();
		t_status();
		t_disable();
		print_verdict();
	end
endmodule : test_debug_access_layer_control
